//--- design/sdram_cmd_pkg.sv
// Constants, command codes and power states of the SDRAM command interface
package sdram_cmd_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int BANKS = 4;
  localparam int ROWS = 4096;
  localparam int COLS = 512;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int BANK_W = 2;
  localparam int ROW_W = 12;
  localparam int COL_W = 9;
  localparam int ADDR_W = 12;
  localparam int CNT_W = 10;
  localparam int IDX_W = BANK_W + ROW_W + COL_W;
  localparam int MEM_WORDS = BANKS * ROWS * COLS;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // Address field positions
  // ----------------------------------------------------------------
  localparam int PRE_FLAG_BIT = 10;
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_WB_BIT = 9;

  // ----------------------------------------------------------------
  // Command codes {row strobe, column strobe, write strobe}, active low
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_LMR = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_BST = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;

  // ----------------------------------------------------------------
  // Burst length codes and the mode register reset value
  // ----------------------------------------------------------------
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [11:0] MODE_RST = 12'h000;

  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_PD_PRE = 2'b01,
    PWR_PD_ACT = 2'b10,
    PWR_SELF_REF = 2'b11
  } pwr_t;

endpackage : sdram_cmd_pkg

//--- design/sdram_command_interface.sv
// Read-data FIFO and the SDRAM command interface top module

module rd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] data;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } fifo_t;

  fifo_t f_q;
  fifo_t f_d;
  logic push;
  logic pop;

  assign in_ready = f_q.cnt != (PW+1)'(DEPTH);
  assign out_valid = f_q.cnt != '0;
  assign out_data = f_q.data[f_q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    f_d = f_q;
    if (push) begin
      f_d.data[f_q.wp] = in_data;
      f_d.wp = PW'(f_q.wp + 1'b1);
    end
    if (pop) begin
      f_d.rp = PW'(f_q.rp + 1'b1);
    end
    f_d.cnt = (PW+1)'(f_q.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end
endmodule : rd_fifo

module sdram_command_interface (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Command strobes
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  // Address
  input wire logic [1:0] BANK_SELECT,
  input wire logic [11:0] ADDRESS_LINES,
  // Data bus, split per direction
  input wire logic [3:0] BYTE_MASK_LANES,
  input wire logic [31:0] DATA_LINES_I,
  output logic [31:0] DATA_LINES_O,
  output logic [3:0] DATA_LINES_OE
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sdram_cmd_pkg::pwr_t pwr;
    logic [3:0] open;
    logic [3:0][11:0] rows;
    logic [11:0] mode;
    logic b_act;
    logic b_wr;
    logic b_ap;
    logic [1:0] b_bank;
    logic [8:0] b_start;
    logic [9:0] b_cnt;
    logic [3:0] dm1;
    logic [3:0] dm2;
    logic [31:0] dout;
    logic [3:0] oe;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic [8:0] col_of(input logic [8:0] st,
      input logic [9:0] c, input logic [2:0] code, input logic ilv);
    logic [8:0] m;
    logic [8:0] cc;
    cc = c[8:0];
    case (code)
      sdram_cmd_pkg::BL_2: m = 9'h001;
      sdram_cmd_pkg::BL_4: m = 9'h003;
      sdram_cmd_pkg::BL_8: m = 9'h007;
      sdram_cmd_pkg::BL_FULL: m = 9'h1FF;
      default: m = 9'h000;
    endcase
    if (ilv && code != sdram_cmd_pkg::BL_FULL) begin
      return (st & ~m) | ((st ^ cc) & m);
    end
    return (st & ~m) | (9'(st + cc) & m);
  endfunction : col_of

  function automatic logic [9:0] len_of(input logic [2:0] code);
    case (code)
      sdram_cmd_pkg::BL_2: return 10'h002;
      sdram_cmd_pkg::BL_4: return 10'h004;
      sdram_cmd_pkg::BL_8: return 10'h008;
      default: return 10'h001;
    endcase
  endfunction : len_of

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic [2:0] cmd;
  logic live;
  logic is_act, is_rd, is_wr, is_pre, is_lmr, is_bst, is_ref;
  logic new_rw;
  logic idle_c;

  // All inputs are used only as sampled at the rising edge
  assign cmd = {RAS_N, CAS_N, WE_N};
  assign live = CKE && s_q.pwr == sdram_cmd_pkg::PWR_RUN;
  assign is_act = live && !CS_N && cmd == sdram_cmd_pkg::CMD_ACT;
  assign is_rd = live && !CS_N && cmd == sdram_cmd_pkg::CMD_RD;
  assign is_wr = live && !CS_N && cmd == sdram_cmd_pkg::CMD_WR;
  assign is_pre = live && !CS_N && cmd == sdram_cmd_pkg::CMD_PRE;
  assign is_lmr = live && !CS_N && cmd == sdram_cmd_pkg::CMD_LMR;
  assign is_bst = live && !CS_N && cmd == sdram_cmd_pkg::CMD_BST;
  assign is_ref = !CS_N && cmd == sdram_cmd_pkg::CMD_REF;
  assign new_rw = is_rd || is_wr;
  assign idle_c = CKE && (CS_N || cmd == sdram_cmd_pkg::CMD_NOP);

  // ----------------------------------------------------------------
  // Access path
  // ----------------------------------------------------------------
  logic [2:0] bl_code;
  logic full_page;
  logic [1:0] acc_bank;
  logic [8:0] acc_col;
  logic [11:0] acc_row;
  logic acc_wr;
  logic acc_ap;
  logic acc_go;
  logic acc_done;
  logic wr_fire;
  logic [9:0] cnt_base;
  logic [9:0] eff_len;
  logic [22:0] acc_idx;
  logic [31:0] rd_word;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [31:0] fifo_out_data;

  assign bl_code = s_q.mode[sdram_cmd_pkg::MODE_BL_LSB +: 3];
  assign full_page = bl_code == sdram_cmd_pkg::BL_FULL;
  assign acc_bank = new_rw ? BANK_SELECT : s_q.b_bank;
  assign cnt_base = new_rw ? 10'h000 : s_q.b_cnt;
  // Column counter runs internally, overridable each cycle
  assign acc_col = new_rw ? ADDRESS_LINES[8:0] :
      col_of(s_q.b_start, s_q.b_cnt, bl_code,
             s_q.mode[sdram_cmd_pkg::MODE_BT_BIT]);
  // Row comes from the bank's latch; the controller opened it first
  assign acc_row = s_q.rows[acc_bank];
  assign acc_wr = new_rw ? is_wr : s_q.b_wr;
  assign acc_ap = new_rw ? ADDRESS_LINES[sdram_cmd_pkg::PRE_FLAG_BIT]
      : s_q.b_ap;
  assign acc_go = live && (new_rw || s_q.b_act) && !is_bst;
  // A full read FIFO stalls the burst rather than dropping data
  assign acc_done = acc_go && (acc_wr || fifo_in_ready);
  assign wr_fire = acc_done && acc_wr;
  assign eff_len = (acc_wr && s_q.mode[sdram_cmd_pkg::MODE_WB_BIT])
      ? 10'h001 : len_of(bl_code);
  assign acc_idx = {acc_bank, acc_row, acc_col};

  // ----------------------------------------------------------------
  // Storage, one array per byte lane
  // ----------------------------------------------------------------
  for (genvar l = 0; l < sdram_cmd_pkg::LANES; l++) begin : gen_lane
    logic [7:0] lane_mem [sdram_cmd_pkg::MEM_WORDS];

    assign rd_word[l*8 +: 8] = lane_mem[acc_idx];

    always_ff @(posedge REF_CLK) begin
      if (wr_fire && !BYTE_MASK_LANES[l]) begin
        lane_mem[acc_idx] <= DATA_LINES_I[l*8 +: 8];
      end
    end

    mask_keep_a:
      assert property (@(posedge REF_CLK) disable iff (RST) wr_fire &&
          BYTE_MASK_LANES[l] |=> lane_mem[$past(acc_idx)] ==
          $past(rd_word[l*8 +: 8]))
      else $error("Masked write byte was stored");
  end

  rd_fifo #(
    .WIDTH(sdram_cmd_pkg::DATA_W),
    .DEPTH(sdram_cmd_pkg::FIFO_DEPTH)
  ) u_rd_fifo (
    .clk(REF_CLK),
    .rst(RST),
    .in_valid(acc_go && !acc_wr),
    .in_ready(fifo_in_ready),
    .in_data(rd_word),
    .out_valid(fifo_out_valid),
    .out_ready(CKE),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Burst bookkeeping
    if (new_rw) begin
      s_d.b_act = 1'b1;
      s_d.b_wr = is_wr;
      s_d.b_ap = acc_ap;
      s_d.b_bank = BANK_SELECT;
      s_d.b_start = ADDRESS_LINES[8:0];
      s_d.b_cnt = 10'h000;
    end
    if (acc_done) begin
      s_d.b_cnt = 10'(cnt_base + 10'h001);
      if (!full_page && 10'(cnt_base + 10'h001) >= eff_len) begin
        s_d.b_act = 1'b0;
        if (acc_ap) begin
          s_d.open[acc_bank] = 1'b0;
        end
      end
    end
    if (is_bst) begin
      s_d.b_act = 1'b0;
    end
    // Row commands; any bank may change during another's burst
    if (is_act) begin
      s_d.open[BANK_SELECT] = 1'b1;
      s_d.rows[BANK_SELECT] = ADDRESS_LINES;
    end
    if (is_pre) begin
      if (ADDRESS_LINES[sdram_cmd_pkg::PRE_FLAG_BIT]) begin
        s_d.open = 4'h0;
      end else begin
        s_d.open[BANK_SELECT] = 1'b0;
      end
    end
    if (is_lmr) begin
      s_d.mode = ADDRESS_LINES;
    end
    // Clock enable and power states
    case (s_q.pwr)
      sdram_cmd_pkg::PWR_RUN: begin
        if (!CKE && !s_q.b_act) begin
          if (is_ref && s_q.open == 4'h0) begin
            s_d.pwr = sdram_cmd_pkg::PWR_SELF_REF;
          end else if (s_q.open == 4'h0) begin
            s_d.pwr = sdram_cmd_pkg::PWR_PD_PRE;
          end else begin
            s_d.pwr = sdram_cmd_pkg::PWR_PD_ACT;
          end
        end
      end
      sdram_cmd_pkg::PWR_PD_PRE, sdram_cmd_pkg::PWR_PD_ACT,
      sdram_cmd_pkg::PWR_SELF_REF: begin
        if (CKE) begin
          s_d.pwr = sdram_cmd_pkg::PWR_RUN;
        end
      end
      default: s_d.pwr = sdram_cmd_pkg::PWR_RUN;
    endcase
    // Output side halts with the clock; data held, mask stays aligned
    if (CKE) begin
      s_d.dm1 = BYTE_MASK_LANES;
      s_d.dm2 = s_q.dm1;
      if (fifo_out_valid) begin
        s_d.dout = fifo_out_data;
        s_d.oe = ~s_q.dm2;
      end else begin
        s_d.oe = 4'h0;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      s_q <= '0;
      s_q.mode <= sdram_cmd_pkg::MODE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign DATA_LINES_O = s_q.dout;
  assign DATA_LINES_OE = s_q.oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  act_opens_row_a:
    assert property (is_act && !acc_done |=>
        s_q.open[$past(BANK_SELECT)] &&
        s_q.rows[$past(BANK_SELECT)] == $past(ADDRESS_LINES))
    else $error("Activate did not open the row");

  deselect_mask_a:
    assert property (CS_N && !s_q.b_act |=>
        s_q.open == $past(s_q.open) && s_q.mode == $past(s_q.mode))
    else $error("Command taken while deselected");

  pre_all_a:
    assert property (is_pre && ADDRESS_LINES[10] |=> s_q.open == 4'h0)
    else $error("Precharge all left a bank open");

  pre_one_a:
    assert property (is_pre && !ADDRESS_LINES[10] && !is_act |=>
        !s_q.open[$past(BANK_SELECT)])
    else $error("Single bank precharge failed");

  mode_load_a:
    assert property (is_lmr |=> s_q.mode == $past(ADDRESS_LINES))
    else $error("Mode op-code not stored");

  read_mask_hiz_a:
    assert property (CKE ##1 CKE ##1 CKE |=>
        (DATA_LINES_OE & $past(BYTE_MASK_LANES, 3)) == 4'h0)
    else $error("Masked read byte driven");

  burst_four_a:
    assert property ((is_wr && bl_code == sdram_cmd_pkg::BL_4 &&
        !s_q.mode[9]) ##1 (idle_c && s_q.b_act) [*2] |=>
        s_q.b_act ##1 !s_q.b_act || !idle_c)
    else $error("Burst of four has wrong length");

  suspend_hold_a:
    assert property (!CKE && s_q.pwr == sdram_cmd_pkg::PWR_RUN |=>
        $stable(s_q.b_cnt) && $stable(DATA_LINES_O))
    else $error("State moved while clock frozen");

  auto_pre_a:
    assert property (new_rw && ADDRESS_LINES[10] && acc_done &&
        bl_code == sdram_cmd_pkg::BL_1 && !is_act |=>
        !s_q.open[$past(BANK_SELECT)])
    else $error("Auto precharge missed");

  pd_exit_a:
    assert property (s_q.pwr != sdram_cmd_pkg::PWR_RUN && CKE |=>
        s_q.pwr == sdram_cmd_pkg::PWR_RUN)
    else $error("Power-down not left on clock enable");

  col_redirect_a:
    assert property (is_rd && s_q.b_act |=>
        s_q.b_start == $past(ADDRESS_LINES[8:0]))
    else $error("New column not taken mid-burst");

  wr_burst_c: cover property (is_wr ##1 idle_c [*3]);
  rd_data_c: cover property (is_rd ##2 (DATA_LINES_OE != 4'h0));
  self_ref_c: cover property (s_q.pwr == sdram_cmd_pkg::PWR_SELF_REF);
  pd_act_c: cover property (s_q.pwr == sdram_cmd_pkg::PWR_PD_ACT);

endmodule : sdram_command_interface

//--- tb/sdram_ctrl_model.sv
// Memory controller model that drives the command and data pins
module sdram_ctrl_model (
  // Clock
  input wire logic clk,
  // Command pins
  output logic cke,
  output logic cs_n,
  output logic [2:0] cmd,
  output logic [1:0] ba,
  output logic [11:0] addr,
  // Write side of the data bus
  output logic [3:0] dm,
  output logic [31:0] dq
);
  timeunit 1ns;
  timeprecision 100ps;

  logic cke_v = 1'b1;
  assign cke = cke_v;

  initial begin
    cs_n = 1'b1;
    cmd = sdram_cmd_pkg::CMD_NOP;
    ba = 2'h0;
    addr = 12'h000;
    dm = 4'h0;
    dq = 32'h00000000;
  end

  // ------------------------------------------------------------
  // Command issue
  // ------------------------------------------------------------
  // Select, strobes and address move together, held a cycle
  // Opening rows before access is left to the caller
  task automatic issue(input logic s, input logic [2:0] c,
                       input logic [1:0] b, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] m,
                       input logic own);
    @(posedge clk);
    #1;
    cs_n = s;
    cmd = c;
    ba = b;
    addr = a;
    dm = m;
    // Released lines flip so stale data never looks valid
    dq = own ? d : ~dq;
  endtask : issue
endmodule : sdram_ctrl_model

//--- tb/test_sdram_command_interface.sv
// Self-checking bench for the SDRAM command interface
module test_sdram_command_interface;
  timeunit 1ns;
  timeprecision 100ps;

  logic REF_CLK;
  logic RST;
  logic cke;
  logic cs_n;
  logic [2:0] cmd;
  logic [1:0] ba;
  logic [11:0] addr;
  logic [3:0] dm;
  logic [31:0] dq;
  logic [31:0] dout;
  logic [3:0] oe;
  logic [31:0] oe_bits;
  logic [31:0] bus;
  logic [31:0] mem [0:2047];
  int err_count = 0;
  int n_tests = 0;

  // Each byte lane belongs to whoever enables it
  assign oe_bits = {{8{oe[3]}}, {8{oe[2]}}, {8{oe[1]}}, {8{oe[0]}}};
  assign bus = (oe_bits & dout) | (~oe_bits & dq);

  sdram_ctrl_model u_sdram_ctrl_model (.clk(REF_CLK), .cke(cke),
    .cs_n(cs_n), .cmd(cmd), .ba(ba), .addr(addr), .dm(dm), .dq(dq));

  sdram_command_interface u_sdram_command_interface (.REF_CLK(REF_CLK),
    .RST(RST), .CKE(cke), .CS_N(cs_n), .RAS_N(cmd[2]), .CAS_N(cmd[1]),
    .WE_N(cmd[0]), .BANK_SELECT(ba), .ADDRESS_LINES(addr),
    .BYTE_MASK_LANES(dm), .DATA_LINES_I(bus), .DATA_LINES_O(dout),
    .DATA_LINES_OE(oe));

  initial begin
    REF_CLK = 1'b0;
    forever #2.5 REF_CLK = ~REF_CLK;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  function automatic int colx(input int s, input int i, input int blk);
    return (s & ~(blk - 1)) | ((s + i) & (blk - 1));
  endfunction : colx

  task automatic drv(input logic s, input logic [2:0] c, input int b,
                     input int a, input logic [31:0] d,
                     input logic [3:0] m, input logic own);
    u_sdram_ctrl_model.issue(s, c, 2'(b), 12'(a), d, m, own);
  endtask : drv

  task automatic op(input logic [2:0] c, input int b, input int a);
    drv(1'b0, c, b, a, 32'h00000000, 4'h0, 1'b0);
  endtask : op

  // Burst of n words, model updated lane by lane
  task automatic wr(input int b, input int c, input int n, input int blk,
                    input int k, input logic [3:0] m);
    logic [31:0] d;
    int a;
    for (int i = 0; i < n; i++) begin
      d = 32'h5A3C0000 + 32'(k * 4096 + b * 256 + i);
      a = b * 512 + colx(c, i, blk);
      drv(1'b0, i == 0 ? sdram_cmd_pkg::CMD_WR : sdram_cmd_pkg::CMD_NOP,
          b, c, d, m, 1'b1);
      for (int l = 0; l < 4; l++) begin
        if (!m[l]) mem[a][8 * l +: 8] = d[8 * l +: 8];
      end
    end
    if (blk == 512) op(sdram_cmd_pkg::CMD_BST, b, 0);
  endtask : wr

  // Mask leads the read by one cycle so every word sees it
  task automatic rd(input int b, input int c, input int n, input int blk,
                    input int h, input logic [3:0] m);
    logic [31:0] lm;
    lm = {{8{~m[3]}}, {8{~m[2]}}, {8{~m[1]}}, {8{~m[0]}}};
    drv(1'b0, sdram_cmd_pkg::CMD_NOP, 0, 0, 32'h00000000, m, 1'b0);
    drv(1'b0, sdram_cmd_pkg::CMD_RD, b, c, 32'h00000000, m, 1'b0);
    drv(1'b0, sdram_cmd_pkg::CMD_NOP, 0, 0, 32'h00000000, m, 1'b0);
    for (int i = 0; i < n; i++) begin
      drv(1'b0, sdram_cmd_pkg::CMD_NOP, 0, 0, 32'h00000000, m, 1'b0);
      cmp(dout & lm, mem[b * 512 + colx(c, i, blk)] & lm);
      cmp({28'h0000000, oe}, {28'h0000000, ~m});
      if (i == 0 && h > 0) begin
        u_sdram_ctrl_model.cke_v = 1'b0;
        repeat (h) begin
          drv(1'b0, sdram_cmd_pkg::CMD_NOP, 0, 0, 32'h00000000, m, 1'b0);
          cmp(dout & lm, mem[b * 512 + c] & lm);
        end
        u_sdram_ctrl_model.cke_v = 1'b1;
      end
    end
    drv(1'b0, blk == 512 ? sdram_cmd_pkg::CMD_BST : sdram_cmd_pkg::CMD_NOP,
        b, 0, 32'h00000000, m, 1'b0);
    if (blk < 512) cmp(32'(oe), 32'h00000000);
  endtask : rd

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic s_reset();
    cmp(dout, 32'h00000000);
    cmp(32'(oe), 32'h00000000);
  endtask : s_reset

  task automatic s_lengths();
    op(sdram_cmd_pkg::CMD_LMR, 0, sdram_cmd_pkg::BL_8);
    op(sdram_cmd_pkg::CMD_ACT, 1, 5);
    wr(1, 0, 8, 8, 1, 4'h0);
    for (int k = 0; k < 4; k++) begin
      op(sdram_cmd_pkg::CMD_LMR, 0, k);
      rd(1, 3, 1 << k, 1 << k, 0, 4'h0);
      if (k == 0) begin
        // Single read with the precharge flag closes the bank
        op(sdram_cmd_pkg::CMD_RD, 1, 12'h403);
        op(sdram_cmd_pkg::CMD_ACT, 1, 5);
        op(sdram_cmd_pkg::CMD_NOP, 0, 0);
        cmp(dout, mem[515]);
      end
    end
  endtask : s_lengths

  task automatic s_order_mask();
    op(sdram_cmd_pkg::CMD_LMR, 0, sdram_cmd_pkg::BL_4);
    wr(1, 6, 4, 4, 2, 4'h0);
    wr(1, 4, 4, 4, 3, 4'h5);
    rd(1, 4, 4, 4, 0, 4'h0);
  endtask : s_order_mask

  task automatic s_suspend();
    rd(1, 4, 4, 4, 2, 4'h6);
  endtask : s_suspend

  task automatic s_cs_high();
    drv(1'b1, sdram_cmd_pkg::CMD_WR, 1, 0, 32'hFFFFFFFF, 4'h0, 1'b1);
    rd(1, 0, 4, 4, 0, 4'h0);
  endtask : s_cs_high

  task automatic s_random();
    int cols [3] = '{4, 7, 5};
    for (int i = 0; i < 5; i++) begin
      drv(1'b0, i < 3 ? sdram_cmd_pkg::CMD_RD : sdram_cmd_pkg::CMD_NOP,
          1, cols[i % 3], 32'h00000000, 4'h0, 1'b0);
      if (i >= 2) cmp(dout, mem[512 + cols[i - 2]]);
    end
    // Let the last burst drain before the bus turns round
    repeat (4) op(sdram_cmd_pkg::CMD_NOP, 0, 0);
  endtask : s_random

  // Row open, no burst: clock enable low gives active power-down
  task automatic s_power();
    u_sdram_ctrl_model.cke_v = 1'b0;
    op(sdram_cmd_pkg::CMD_NOP, 0, 0);
    op(sdram_cmd_pkg::CMD_RD, 1, 4);
    // Read lands on the exit edge and must be ignored
    u_sdram_ctrl_model.cke_v = 1'b1;
    op(sdram_cmd_pkg::CMD_NOP, 0, 0);
    op(sdram_cmd_pkg::CMD_NOP, 0, 0);
    cmp({28'h0000000, oe}, 32'h00000000);
  endtask : s_power

  task automatic s_banks();
    op(sdram_cmd_pkg::CMD_ACT, 2, 5);
    wr(2, 4, 4, 4, 4, 4'h0);
    op(sdram_cmd_pkg::CMD_PRE, 2, 0);
    rd(1, 4, 4, 4, 0, 4'h0);
    op(sdram_cmd_pkg::CMD_ACT, 2, 5);
    rd(2, 4, 4, 4, 0, 4'h0);
  endtask : s_banks

  task automatic s_full_page();
    op(sdram_cmd_pkg::CMD_PRE, 0, 12'h400);
    op(sdram_cmd_pkg::CMD_LMR, 0, sdram_cmd_pkg::BL_FULL);
    op(sdram_cmd_pkg::CMD_ACT, 1, 5);
    wr(1, 510, 3, 512, 5, 4'h0);
    rd(1, 510, 3, 512, 0, 4'h0);
  endtask : s_full_page

  task automatic results();
    $display("Comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge REF_CLK);
    err_count++;
    results();
  end

  initial begin
    RST = 1'b1;
    repeat (5) @(posedge REF_CLK);
    #1;
    RST = 1'b0;
    s_reset();
    s_lengths();
    s_order_mask();
    s_suspend();
    s_cs_high();
    s_random();
    s_power();
    s_banks();
    s_full_page();
    results();
  end
endmodule : test_sdram_command_interface
